// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the main clock controller
// Assumes: Oscillator waves made here at a quarter of the system clock
// Notes: Inputs change on the rising edge, outputs are sampled on the falling edge
`include "mcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top import mcp_pkg::*;;
  // ============================================================
  // Stimulus and observed signals
  localparam logic [5:0] FA = 6'h2A;  // Arbitrary factory trims
  localparam logic [5:0] FB = 6'h15;
  localparam logic [3:0] TA = 4'h3;
  localparam logic [3:0] TB = 4'hC;
  localparam logic [3:0] CODES [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA,
    4'hB, 4'hC, 4'h6, 4'hF};
  localparam int RATIOS [13] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 2, 2};
  logic clk = 1'b0;
  logic srst = 1'b1;
  mcp_bus_t bus = '0;
  logic key = 1'b0, ins = 1'b0, fz = 1'b0, slp = 1'b0, inuse = 1'b0, ph = 1'b0;
  logic [1:0] fsel = 2'h0;
  logic [3:0] rdy = 4'hF, tick = 4'h0, req = 4'h0;
  logic [7:0] rdata;
  logic [3:0] pwr;
  logic [1:0] msrc;
  logic pclk, pin;
  logic [5:0] ftrim;
  logic [3:0] ttrim;
  logic [7:0] d;
  int mismatches = 0, total_checks = 0, cyc = 0, g, c;
  mcp_clock_ctrl #(.FREQ_TRIM_A(FA), .FREQ_TRIM_B(FB), .TEMP_TRIM_A(TA), .TEMP_TRIM_B(TB))
  mcp_clock_ctrl_inst (.clk(clk), .srst(srst), .reg_bus(bus), .reg_rdata(rdata),
    .guard_key_written(key), .instr_done(ins), .fuse_osc_freeze(fz), .fuse_freq_choice(fsel),
    .osc_ready_async(rdy), .osc_tick_async(tick), .periph_src_req(req), .sleeping(slp),
    .sysclk_in_use(inuse), .osc_power(pwr), .main_src(msrc), .periph_clock(pclk),
    .sys_clock_pin_out(pin), .fast_rc_freq_trim(ftrim), .fast_rc_temp_trim(ttrim));
  // ============================================================
  // Clock, oscillator waves of period four cycles, hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    ph <= ~ph;
    if (ph) begin
      tick <= ~tick;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end
  // ============================================================
  // Shared tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  // Key pulse, n retired instructions, then the write
  task automatic pw(input logic [7:0] a, input logic [7:0] v, input int n = 0);
    @(posedge clk);
    key <= 1'b1;
    @(posedge clk);
    key <= 1'b0;
    repeat (n) begin
      @(posedge clk);
      ins <= 1'b1;
      @(posedge clk);
      ins <= 1'b0;
    end
    wr(a, v);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    d = rdata;
    chk(nm, {8'h00, d}, {8'h00, exp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rst(input logic f, input logic [1:0] s);
    @(posedge clk);
    fz <= f;
    fsel <= s;
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
  endtask
  // Cycles between two peripheral clock pulses, both waits bounded
  task automatic gap(output int n);
    int k;
    k = 0;
    @(negedge clk);
    while (pclk !== 1'b1 && k < 1000) begin
      @(negedge clk);
      k++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pclk !== 1'b1 && n < 1000);
  endtask
  task automatic src_wait(input logic [1:0] s, output int k);
    k = 0;
    while (msrc !== s && k < 400) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic flips(output int n);
    logic last;
    n = 0;
    @(negedge clk);
    last = pin;
    repeat (40) begin
      @(negedge clk);
      if (pin !== last) begin
        n++;
      end
      last = pin;
    end
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset();
    rchk("status", `MCP_OFS_STATUS, 8'h00);
    rchk("ctrl_a", `MCP_OFS_CTRL_A, 8'h00);
    rchk("ctrl_b", `MCP_OFS_CTRL_B, 8'h11);
    rchk("lock", `MCP_OFS_LOCK, 8'h00);
    rchk("fast_ctrl", `MCP_OFS_FAST_CTRL, 8'h00);
    rchk("slow_ctrl", `MCP_OFS_SLOW_CTRL, 8'h00);
    rchk("freq", `MCP_OFS_FAST_FREQ, {2'h0, FB});
    rchk("temp", `MCP_OFS_FAST_TEMP, {4'h0, TB});
    rchk("unmapped", 8'h04, 8'h00);
    chk("ttrim", {12'h000, ttrim}, {12'h000, TB});
    $display("test reset done");
  endtask
  task automatic t_guard();
    wr(`MCP_OFS_CTRL_B, 8'h03);
    rchk("no key", `MCP_OFS_CTRL_B, 8'h11);
    pw(`MCP_OFS_CTRL_B, 8'h03, 3);
    rchk("3 instr", `MCP_OFS_CTRL_B, 8'h03);
    wr(`MCP_OFS_CTRL_B, 8'h05);
    rchk("consumed", `MCP_OFS_CTRL_B, 8'h03);
    pw(`MCP_OFS_CTRL_B, 8'h05, 4);
    rchk("4 instr", `MCP_OFS_CTRL_B, 8'h03);
    pw(`MCP_OFS_FAST_FREQ, 8'h3F);
    rchk("freq", `MCP_OFS_FAST_FREQ, 8'h3F);
    chk("ftrim", {10'h000, ftrim}, 16'h003F);
    $display("test guard done");
  endtask
  // First gap after a change is discarded, its phase is arbitrary
  task automatic t_prescale();
    for (int i = 0; i < 13; i++) begin
      pw(`MCP_OFS_CTRL_B, {3'h0, CODES[i], 1'b1});
      gap(g);
      gap(g);
      chk("ratio", 16'(g), 16'(RATIOS[i] * 4));
    end
    pw(`MCP_OFS_CTRL_B, 8'h0A);
    gap(g);
    gap(g);
    chk("undivided", 16'(g), 16'h0004);
    $display("test prescale done");
  endtask
  task automatic t_pin();
    pw(`MCP_OFS_CTRL_A, 8'h80);
    flips(c);
    chk("pin run", 16'(c), 16'h000A);
    @(posedge clk);
    slp <= 1'b1;
    idle(4);
    flips(c);
    chk("pin sleep", {15'h0000, pin}, 16'h0000);
    chk("sleep flips", 16'(c), 16'h0000);
    @(posedge clk);
    inuse <= 1'b1;
    flips(c);
    chk("pin in use", 16'(c), 16'h000A);
    @(posedge clk);
    slp <= 1'b0;
    inuse <= 1'b0;
    pw(`MCP_OFS_CTRL_A, 8'h00);
    idle(4);
    flips(c);
    chk("pin off", {15'h0000, pin}, 16'h0000);
    chk("off flips", 16'(c), 16'h0000);
    $display("test pin done");
  endtask
  task automatic t_switch();
    @(posedge clk);
    rdy[1] <= 1'b0;
    pw(`MCP_OFS_CTRL_A, 8'h01);
    idle(40);
    rchk("switching", `MCP_OFS_STATUS, 8'h11);
    chk("held src", {14'h0000, msrc}, 16'h0000);
    @(posedge clk);
    rdy[1] <= 1'b1;
    src_wait(2'h1, g);
    rchk("ulp status", `MCP_OFS_STATUS, 8'h20);
    for (int s = 2; s < 5; s++) begin
      pw(`MCP_OFS_CTRL_A, 8'(s % 4));
      src_wait(2'(s % 4), g);
      idle(2);  // Power request lags the new source by a cycle
      chk("src", {14'h0000, msrc}, 16'(s % 4));
      chk("power", {12'h000, pwr}, 16'(1 << (s % 4)));
      rchk("status", `MCP_OFS_STATUS, 8'(8'h10 << (s % 4)));
      if (s == 2) begin
        chk("gate delay", 16'(g >= 12 && g <= 30), 16'h0001);
      end
    end
    @(posedge clk);
    req <= 4'h4;
    idle(40);
    rchk("req status", `MCP_OFS_STATUS, 8'h50);
    chk("req power", {12'h000, pwr}, 16'h0005);
    @(posedge clk);
    req <= 4'h0;
    pw(`MCP_OFS_SLOW_CTRL, 8'h02);
    idle(40);
    chk("slow forced", {12'h000, pwr}, 16'h0003);
    rchk("forced status", `MCP_OFS_STATUS, 8'h10);
    pw(`MCP_OFS_CTRL_A, 8'h01);
    src_wait(2'h1, g);
    pw(`MCP_OFS_FAST_CTRL, 8'h02);
    idle(40);
    chk("fast forced", {12'h000, pwr}, 16'h0003);
    rchk("fast gated", `MCP_OFS_STATUS, 8'h20);
    pw(`MCP_OFS_CTRL_A, 8'h00);
    src_wait(2'h0, g);
    $display("test switch done");
  endtask
  task automatic t_lock();
    pw(`MCP_OFS_CTRL_B, 8'h03);
    pw(`MCP_OFS_LOCK, 8'h01);
    rchk("lock read", `MCP_OFS_LOCK, 8'h00);
    pw(`MCP_OFS_CTRL_B, 8'h05);
    rchk("frozen b", `MCP_OFS_CTRL_B, 8'h03);
    pw(`MCP_OFS_CTRL_A, 8'h01);
    idle(40);
    chk("frozen src", {14'h0000, msrc}, 16'h0000);
    pw(`MCP_OFS_FAST_FREQ, 8'h01);
    rchk("frozen trim", `MCP_OFS_FAST_FREQ, 8'h3F);
    pw(`MCP_OFS_LOCK, 8'h00);
    pw(`MCP_OFS_CTRL_B, 8'h05);
    rchk("still frozen", `MCP_OFS_CTRL_B, 8'h03);
    rst(1'b1, 2'h1);
    rchk("fuse temp", `MCP_OFS_FAST_TEMP, {4'h8, TA});
    rchk("fuse freq", `MCP_OFS_FAST_FREQ, {2'h0, FA});
    pw(`MCP_OFS_FAST_TEMP, 8'h05);
    rchk("fuse temp kept", `MCP_OFS_FAST_TEMP, {4'h8, TA});
    pw(`MCP_OFS_CTRL_B, 8'h05);
    rchk("fuse frozen", `MCP_OFS_CTRL_B, 8'h11);
    $display("test lock done");
  endtask
  // ============================================================
  // Main sequence
  initial begin
    rst(1'b0, 2'h0);
    t_reset();
    t_guard();
    t_prescale();
    t_pin();
    t_switch();
    t_lock();
    final_report();
  end
endmodule
`default_nettype wire

// >>> core/mcp_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the clock controller
// Assumes: 8-bit register port, 200 MHz system clock
// Notes: Included by the clock controller core and by the bench
`ifndef MCP_CFG_SVH
`define MCP_CFG_SVH
// ============================================================
// Register offsets
`define MCP_OFS_CTRL_A 8'h00
`define MCP_OFS_CTRL_B 8'h01
`define MCP_OFS_LOCK 8'h02
`define MCP_OFS_STATUS 8'h03
`define MCP_OFS_FAST_CTRL 8'h10
`define MCP_OFS_FAST_FREQ 8'h11
`define MCP_OFS_FAST_TEMP 8'h12
`define MCP_OFS_SLOW_CTRL 8'h18
// ============================================================
// Field positions
`define MCP_POS_SYS_CLOCK_PIN_OUT 7
`define MCP_POS_PRESCALE_ON 0
`define MCP_POS_FREEZE 0
`define MCP_POS_EXT_STARTED 7
`define MCP_POS_SWITCHING 0
`define MCP_POS_FORCE_ON 1
`define MCP_POS_FUSE_FREEZE 7
// ============================================================
// Reset values
`define MCP_RST_CTRL_A 8'h00
`define MCP_RST_CTRL_B 8'h11
`define MCP_RST_FORCE 1'h0
// ============================================================
// Timing counts
`define MCP_GUARD_INSTR 3'h4
`define MCP_GATE_TICKS 3'h4
`define MCP_EXT_START_TICKS 3'h2
`endif

// >>> core/mcp_clock_ctrl.sv
// Purpose: Main clock select, prescaler, lock and oscillator gating control
// Assumes: Oscillator ready levels and cycle ticks arrive asynchronously
// Notes: Clocks are modelled as one-cycle enable pulses on clk
//
// Contract
// - Clock-out bit drives system clock onto clock pin.
// - In sleep, pin idle unless a peripheral still uses system clock.
// - Selector 0 fast RC, 1 ULP RC, 2 crystal, 3 external clock.
// - Divider codes 0-5 give 2..64, codes 8-C give 6,10,12,24,48.
// - Prescaler ratio may change while running.
// - Prescaler off passes main clock undivided.
// - Freeze bit blocks main control and current source calibration writes.
// - Once frozen, freeze register inaccessible until hardware reset.
// - Freeze bit loaded from fuse at reset.
// - Status bit 7 shows external clock started.
// - Stable flags need a stable and requested source.
// - Switching flag high until new source stable, then main moves.
// - Force-on bit keeps fast RC running always.
// - Fast RC gives no clock unless requested.
// - Gate opens four oscillator ticks after request, two ticks for the external clock.
// - Frequency trim loaded from factory value by fuse choice.
// - Fuse freeze flag blocks both calibration registers.
// - Temperature trim loaded from factory value by fuse choice.
// - Protected writes need guard key and write within four instructions.
// - ULP RC force-on bit keeps it on; gate after four ticks.
//
// Implementation choice: strobed register access.
`include "mcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mcp_clock_ctrl import mcp_pkg::*; #(
  parameter logic [5:0] FREQ_TRIM_A = 6'h20,  // Arbitrary factory value
  parameter logic [5:0] FREQ_TRIM_B = 6'h21,  // Arbitrary factory value
  parameter logic [3:0] TEMP_TRIM_A = 4'h8,  // Arbitrary factory value
  parameter logic [3:0] TEMP_TRIM_B = 4'h9  // Arbitrary factory value
) (
  input wire logic clk,
  input wire logic srst,
  input wire mcp_bus_t reg_bus,
  output logic [7:0] reg_rdata,
  input wire logic guard_key_written,
  input wire logic instr_done,
  input wire logic fuse_osc_freeze,
  input wire logic [1:0] fuse_freq_choice,
  input wire logic [3:0] osc_ready_async,
  input wire logic [3:0] osc_tick_async,
  input wire logic [3:0] periph_src_req,
  input wire logic sleeping,
  input wire logic sysclk_in_use,
  output logic [3:0] osc_power,
  output logic [1:0] main_src,
  output logic periph_clock,
  output logic sys_clock_pin_out,
  output logic [5:0] fast_rc_freq_trim,
  output logic [3:0] fast_rc_temp_trim
);
  // ============================================================
  // Functions
  // Division ratio per code; reserved codes fall back to two
  function automatic logic [6:0] ratio_of(input logic [3:0] code);
    case (code)
      4'h0: ratio_of = 7'h02;
      4'h1: ratio_of = 7'h04;
      4'h2: ratio_of = 7'h08;
      4'h3: ratio_of = 7'h10;
      4'h4: ratio_of = 7'h20;
      4'h5: ratio_of = 7'h40;
      4'h8: ratio_of = 7'h06;
      4'h9: ratio_of = 7'h0A;
      4'hA: ratio_of = 7'h0C;
      4'hB: ratio_of = 7'h18;
      4'hC: ratio_of = 7'h30;
      default: ratio_of = 7'h02;
    endcase
  endfunction
  function automatic logic hit(input mcp_bus_t b, input logic [7:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction

  // ============================================================
  // Registers and state
  logic clk_out_en;
  logic [1:0] sel_target;
  logic prescale_on;
  logic [3:0] prescale_ratio;
  logic main_cfg_freeze;
  logic fast_force_on;
  logic ulp_force_on;
  logic fuse_freeze;
  logic main_src_switching;
  mcp_sw_state_t sw_state;
  logic [2:0] guard_cnt;
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [3:0] tick_prev;
  logic [2:0] gate_cnt [4];
  logic [3:0] gate_open;
  logic [6:0] div_cnt;
  logic [3:0] requested;
  logic [3:0] ready;
  logic [3:0] tick;
  logic [3:0] src_stable;
  logic guard_open;
  logic wr_ok;
  logic main_tick;
  logic clk_out_allowed;
  logic cal_frozen;
  logic [6:0] ratio;

  // ============================================================
  // Synchronisers for oscillator status and ticks
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
      tick_prev <= 4'h0;
    end else begin
      sync_a <= {osc_ready_async, osc_tick_async};
      sync_b <= sync_a;
      tick_prev <= sync_b[3:0];
    end
  end
  // Rising edge of a source marks one oscillator cycle
  assign tick = sync_b[3:0] & ~tick_prev;
  assign ready = sync_b[7:4];

  // ============================================================
  // Guard window: open for four instructions after the key
  always_ff @(posedge clk) begin
    if (srst) begin
      guard_cnt <= 3'h0;
    end else if (guard_key_written) begin
      guard_cnt <= `MCP_GUARD_INSTR;
    end else if (wr_ok) begin
      guard_cnt <= 3'h0;  // One protected write per key
    end else if (instr_done && guard_cnt != 3'h0) begin
      guard_cnt <= guard_cnt - 3'h1;
    end
  end
  assign guard_open = (guard_cnt != 3'h0);
  assign wr_ok = reg_bus.wr && guard_open;
  // Fast RC calibration frozen by fuse, or by main freeze if it drives main
  assign cal_frozen = fuse_freeze ||
    (main_cfg_freeze && main_src == MCP_SRC_FAST_RC);

  // ============================================================
  // Main control A and B, frozen by the lock
  always_ff @(posedge clk) begin
    if (srst) begin
      // Reset words cut down to field width on purpose
      clk_out_en <= 1'(`MCP_RST_CTRL_A >> `MCP_POS_SYS_CLOCK_PIN_OUT);
      sel_target <= 2'(`MCP_RST_CTRL_A & 8'h03);
      prescale_on <= 1'(`MCP_RST_CTRL_B & 8'h01);
      prescale_ratio <= 4'((`MCP_RST_CTRL_B >> 1) & 8'h0F);
    end else if (wr_ok && !main_cfg_freeze) begin
      if (hit(reg_bus, `MCP_OFS_CTRL_A)) begin
        clk_out_en <= reg_bus.wdata[`MCP_POS_SYS_CLOCK_PIN_OUT];
        sel_target <= reg_bus.wdata[1:0];
      end
      if (hit(reg_bus, `MCP_OFS_CTRL_B)) begin
        prescale_on <= reg_bus.wdata[`MCP_POS_PRESCALE_ON];
        prescale_ratio <= reg_bus.wdata[4:1];
      end
    end
  end

  // Lock: fuse sets it at reset, only a reset clears it
  always_ff @(posedge clk) begin
    if (srst) begin
      main_cfg_freeze <= fuse_osc_freeze;
      fuse_freeze <= fuse_osc_freeze;
    end else if (wr_ok && !main_cfg_freeze && hit(reg_bus, `MCP_OFS_LOCK)) begin
      main_cfg_freeze <= reg_bus.wdata[`MCP_POS_FREEZE];
    end
  end

  // Oscillator control and calibration
  always_ff @(posedge clk) begin
    if (srst) begin
      fast_force_on <= `MCP_RST_FORCE;
      ulp_force_on <= `MCP_RST_FORCE;
      fast_rc_freq_trim <= (fuse_freq_choice == 2'h1) ? FREQ_TRIM_A : FREQ_TRIM_B;
      fast_rc_temp_trim <= (fuse_freq_choice == 2'h1) ? TEMP_TRIM_A : TEMP_TRIM_B;
    end else if (wr_ok) begin
      if (hit(reg_bus, `MCP_OFS_FAST_CTRL)) begin
        fast_force_on <= reg_bus.wdata[`MCP_POS_FORCE_ON];
      end
      if (hit(reg_bus, `MCP_OFS_SLOW_CTRL)) begin
        ulp_force_on <= reg_bus.wdata[`MCP_POS_FORCE_ON];
      end
      if (hit(reg_bus, `MCP_OFS_FAST_FREQ) && !cal_frozen) begin
        fast_rc_freq_trim <= reg_bus.wdata[5:0];
      end
      if (hit(reg_bus, `MCP_OFS_FAST_TEMP) && !cal_frozen) begin
        fast_rc_temp_trim <= reg_bus.wdata[3:0];
      end
    end
  end

  // ============================================================
  // Requests, power and clock gates
  always_comb begin
    requested = periph_src_req;
    requested[main_src] = 1'b1;
    if (main_src_switching) begin
      requested[sel_target] = 1'b1;
    end
  end
  // Forced-on sources skip analog start-up, so count as ready at once
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_power <= 4'h0;
    end else begin
      osc_power <= requested | {2'b00, ulp_force_on, fast_force_on};
    end
  end
  for (genvar i = 0; i < 4; i++) begin : g_gate
    logic [2:0] limit;
    logic up;
    assign limit = (i == 3) ? `MCP_EXT_START_TICKS : `MCP_GATE_TICKS;
    assign up = ready[i] || (i == 0 && fast_force_on) || (i == 1 && ulp_force_on);
    // Gate counts oscillator ticks after a request
    always_ff @(posedge clk) begin
      if (srst || !requested[i]) begin
        gate_cnt[i] <= 3'h0;
      end else if (up && tick[i] && gate_cnt[i] != limit) begin
        gate_cnt[i] <= gate_cnt[i] + 3'h1;
      end
    end
    assign gate_open[i] = requested[i] && (gate_cnt[i] == limit);
  end
  assign src_stable = gate_open;

  // ============================================================
  // Source switch: old source runs until new one is stable
  always_ff @(posedge clk) begin
    if (srst) begin
      sw_state <= MCP_SW_IDLE;
      main_src <= 2'(`MCP_RST_CTRL_A & 8'h03);
      main_src_switching <= 1'b0;
    end else begin
      case (sw_state)
        MCP_SW_IDLE: begin
          if (sel_target != main_src) begin
            sw_state <= MCP_SW_WAIT;
            main_src_switching <= 1'b1;
          end
        end
        MCP_SW_WAIT: begin
          if (src_stable[sel_target]) begin
            main_src <= sel_target;
            main_src_switching <= 1'b0;
            sw_state <= MCP_SW_IDLE;
          end
        end
        default: begin
          sw_state <= MCP_SW_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Prescaler
  assign main_tick = tick[main_src] && gate_open[main_src];
  assign ratio = ratio_of(prescale_ratio);
  // Counter wraps on a shrunk ratio so a live change never stalls
  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt <= 7'h00;
      periph_clock <= 1'b0;
    end else if (!prescale_on) begin
      div_cnt <= 7'h00;
      periph_clock <= main_tick;
    end else if (main_tick) begin
      if (div_cnt >= ratio - 7'h01) begin
        div_cnt <= 7'h00;
        periph_clock <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 7'h01;
        periph_clock <= 1'b0;
      end
    end else begin
      periph_clock <= 1'b0;
    end
  end

  // Clock pin toggles on each system clock pulse
  assign clk_out_allowed = clk_out_en && (!sleeping || sysclk_in_use);
  always_ff @(posedge clk) begin
    if (srst || !clk_out_allowed) begin
      sys_clock_pin_out <= 1'b0;
    end else if (periph_clock) begin
      sys_clock_pin_out <= !sys_clock_pin_out;
    end
  end

  // ============================================================
  // Read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_bus.rd) begin
      case (reg_bus.addr)
        `MCP_OFS_CTRL_A: reg_rdata <= {clk_out_en, 5'h00, sel_target};
        `MCP_OFS_CTRL_B: reg_rdata <= {3'h0, prescale_ratio, prescale_on};
        `MCP_OFS_LOCK: reg_rdata <= {7'h00, 1'b0};  // Hidden; reads zero
        `MCP_OFS_STATUS: reg_rdata <= {src_stable[3], src_stable[2], src_stable[1],
                                       src_stable[0], 3'h0, main_src_switching};
        `MCP_OFS_FAST_CTRL: reg_rdata <= {6'h00, fast_force_on, 1'b0};
        `MCP_OFS_FAST_FREQ: reg_rdata <= {2'h0, fast_rc_freq_trim};
        `MCP_OFS_FAST_TEMP: reg_rdata <= {fuse_freeze, 3'h0, fast_rc_temp_trim};
        `MCP_OFS_SLOW_CTRL: reg_rdata <= {6'h00, ulp_force_on, 1'b0};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ============================================================
  // Assertions
  a_lock_blocks_ctrl: assert property (@(posedge clk) disable iff (srst)
    main_cfg_freeze && hit(reg_bus, `MCP_OFS_CTRL_B) |=>
    $stable(prescale_ratio) && $stable(prescale_on))
    else $error("control B changed while frozen");
  a_freeze_sticky: assert property (@(posedge clk) disable iff (srst)
    main_cfg_freeze |=> main_cfg_freeze [*8])
    else $error("freeze cleared without reset");
  a_pin_sleep: assert property (@(posedge clk) disable iff (srst)
    sleeping && !sysclk_in_use |=> !sys_clock_pin_out)
    else $error("clock pin active in sleep");
  a_pin_toggle: assert property (@(posedge clk) disable iff (srst)
    clk_out_allowed && periph_clock |=> sys_clock_pin_out != $past(sys_clock_pin_out))
    else $error("clock pin missed a pulse");
  a_switch_wait: assert property (@(posedge clk) disable iff (srst)
    main_src_switching && !src_stable[sel_target] |=> $stable(main_src))
    else $error("main source moved before stable");
  a_switch_done: assert property (@(posedge clk) disable iff (srst)
    sw_state == MCP_SW_WAIT && src_stable[sel_target] |=>
    !main_src_switching && main_src == $past(sel_target))
    else $error("switch did not complete");
  a_guard_needed: assert property (@(posedge clk) disable iff (srst)
    !guard_open && hit(reg_bus, `MCP_OFS_FAST_CTRL) |=> $stable(fast_force_on))
    else $error("unguarded write took effect");
  // A fresh fast RC request may not read stable in its first four cycles
  a_stable_req: assert property (@(posedge clk) disable iff (srst)
    !requested[0] ##1 requested[0] |-> !src_stable[0] [*4])
    else $error("gate opened before four ticks");
  a_undivided: assert property (@(posedge clk) disable iff (srst)
    !prescale_on && main_tick |=> periph_clock)
    else $error("undivided clock lost a pulse");
  a_trim_fuse: assert property (@(posedge clk) disable iff (srst)
    fuse_freeze && hit(reg_bus, `MCP_OFS_FAST_FREQ) |=> $stable(fast_rc_freq_trim))
    else $error("trim changed under fuse freeze");
  // Lock register stays hidden from reads whatever it holds
  a_lock_hidden: assert property (@(posedge clk) disable iff (srst)
    reg_bus.rd && reg_bus.addr == `MCP_OFS_LOCK |=> reg_rdata == 8'h00)
    else $error("lock register readable");
  a_freeze_temp: assert property (@(posedge clk) disable iff (srst)
    main_cfg_freeze && main_src == MCP_SRC_FAST_RC && hit(reg_bus, `MCP_OFS_FAST_TEMP) |=>
    $stable(fast_rc_temp_trim))
    else $error("temperature trim changed while frozen");
  c_switch: cover property (@(posedge clk) disable iff (srst)
    main_src_switching ##[1:200] !main_src_switching);
  c_divide: cover property (@(posedge clk) disable iff (srst)
    prescale_on && periph_clock);
  c_freeze: cover property (@(posedge clk) disable iff (srst)
    $rose(main_cfg_freeze));
  c_undivided: cover property (@(posedge clk) disable iff (srst)
    !prescale_on && periph_clock);
endmodule
`default_nettype wire

// >>> core/mcp_pkg.sv
// Purpose: Types shared by the clock controller
// Assumes: Nothing beyond the cfg header
// Notes: Holds types only
package mcp_pkg;
  // ============================================================
  // Main clock sources, one-hot index order matches selector code
  typedef enum logic [1:0] {
    MCP_SRC_FAST_RC = 2'h0,
    MCP_SRC_ULP_RC = 2'h1,
    MCP_SRC_CRYSTAL = 2'h2,
    MCP_SRC_EXT = 2'h3
  } mcp_src_t;
  // Source switch sequencer
  typedef enum logic [1:0] {
    MCP_SW_IDLE = 2'b01,
    MCP_SW_WAIT = 2'b10
  } mcp_sw_state_t;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mcp_bus_t;
endpackage
